// ===== ushr_pkg.sv
// Shared constants for the handshake and timer-start reservation block
package ushr_pkg;
  // ---------------------------------------------------------------
  // Device register selects and reset values
  // ---------------------------------------------------------------
  localparam logic       SEL_TIMER     = 1'b0;
  localparam logic       SEL_HANDSHAKE = 1'b1;
  localparam logic [15:0] TIMER_ARM_ADDR = 16'hFF6C; // Documented offset
  localparam logic [7:0] TIMER_RST     = 8'h01;
  localparam logic [7:0] TIMER_MASK    = 8'h03;
  localparam logic [7:0] HANDSHAKE_RST = 8'h00;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TMR_ARM_TOKEN   = 0;
  localparam int TMR_ARM_TX      = 1;
  localparam int HS_ACK          = 0;
  localparam int HS_DATA_NAK     = 1;
  localparam int HS_EP0_NAK      = 2;
  localparam int HS_EP1_NAK      = 3;
  localparam int HS_DATA_STALL   = 4;
  localparam int HS_LEN_STALL    = 5;
  localparam int HS_EP0_STALL    = 6;
  localparam int HS_EP1_STALL    = 7;
  // ---------------------------------------------------------------
  // Controller APB map
  // ---------------------------------------------------------------
  localparam logic [31:0] APB_CMD    = 32'h0000_0000;
  localparam logic [31:0] APB_STATUS = 32'h0000_0004;
  localparam logic [31:0] APB_MASK   = 32'h0000_0008;
  localparam int CMD_SEL     = 8;
  localparam int CMD_BITMODE = 9;
  localparam int CMD_IDX_LO  = 10;
  localparam int CMD_IDX_HI  = 12;
  localparam int STS_HS_LO   = 8;
  localparam int STS_REFUSED = 16;
  localparam int STS_MASK    = 17;
endpackage : ushr_pkg

// ===== ushr_if.sv
// Carrier joining the reservation block and its controller
`timescale 1ns/1ns
`default_nettype none
interface ushr_if;
  logic       wr_en;        // One-cycle write strobe
  logic       wr_sel;       // Register select
  logic       wr_bit_mode;  // Single-bit write
  logic [2:0] wr_bit_idx;   // Bit index for single-bit write
  logic [7:0] wr_data;      // Byte data, bit 0 for single-bit
  logic [7:0] rd_timer;     // Timer-start arm register
  logic [7:0] rd_handshake; // Handshake reservation register

  modport dev (input wr_en, wr_sel, wr_bit_mode, wr_bit_idx, wr_data,
               output rd_timer, rd_handshake);
  modport ctl (output wr_en, wr_sel, wr_bit_mode, wr_bit_idx, wr_data,
               input rd_timer, rd_handshake);
endinterface : ushr_if
`default_nettype wire

// ===== ushr_dev.sv
// Handshake reply and timer-start reservation logic
// Operation
// [RL1] Endpoint-0 NAK after qualified IN token; the code requires endpoint_zero_hit_in clear for this NAK
// [RL2] Data NAK after qualified OUT data
// [RL3] Software sets data NAK while saving data
// [RL4] ACK after clean data packet
// [RL5] Endpoint 0 IN: one reservation only
// [RL6] Endpoint 1 IN: one reservation only
// [RL7] No data NAK with STALL or ACK
// [RL8] Data NAK reservation sets write mask
// [RL9] Decode and error signals not readable
// [RL10] Timer arm register resets to 01H
// [RL11] SETUP reception forces timer arm 01H
// [RL12] Timer arm: bit1 tx, bit0 token
// [RL13] Timer start after clean data transmit
// [RL14] Timer start after qualified SETUP/OUT token
// [RL15] Clear arm flag blocks timer start
// [RL16] Single-bit and byte writes accepted
// [RL17] Handshake register clears on reset, SETUP
// [RL18] Handshake bits: ACK, NAK, STALL groups
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
`default_nettype none
module ushr_dev
  import ushr_pkg::*;
(
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Register access
  ushr_if.dev       bus,
  // Packet events, one-cycle pulses at EOP
  input  wire logic token_eop_in,
  input  wire logic data_rx_eop_in,
  input  wire logic data_tx_eop_in,
  // Token decode
  input  wire logic in_token_seen_in,
  input  wire logic out_token_seen_in,
  input  wire logic setup_token_seen_in,
  input  wire logic token_pid_valid_in,
  input  wire logic address_match_in,
  input  wire logic endpoint_zero_hit_in,
  input  wire logic token_length_err_in,
  input  wire logic token_bit_err_in,
  input  wire logic token_crc_err_in,
  // Data decode
  input  wire logic data_pid_valid_in,
  input  wire logic data_length_err_in,
  input  wire logic data_bit_err_in,
  input  wire logic data_crc_err_in,
  input  wire logic clock_watchdog_err_in,
  // Replies, one-cycle pulses
  output logic      nak_send_out,
  output logic      ack_send_out,
  output logic      timer_start_out
);
  // ---------------------------------------------------------------
  // Qualification terms (internal only, never on the register port)
  // ---------------------------------------------------------------
  logic token_ok;
  logic data_ok;
  logic setup_rx;
  logic ep0_nak_hit;
  logic data_nak_hit;
  logic ack_hit;
  logic tx_start_hit;
  logic tok_start_hit;

  // Register state and next values
  logic [7:0] timer_arm;
  logic [7:0] reserve;
  logic [7:0] next_timer_arm;
  logic [7:0] next_reserve;
  // Reply pulse flops and next values
  logic       nak_q;
  logic       ack_q;
  logic       start_q;
  logic       next_nak;
  logic       next_ack;
  logic       next_start;

  // ---------------------------------------------------------------
  // Error-free token and data views
  // ---------------------------------------------------------------
  // Token passed length, bit and CRC checks
  assign token_ok = !token_length_err_in &&
                    !token_bit_err_in &&
                    !token_crc_err_in;  // [RL9]
  // Valid data ID, no length, bit or CRC fault
  assign data_ok  = data_pid_valid_in &&
                    !data_length_err_in &&
                    !data_bit_err_in &&
                    !data_crc_err_in;
  // Clean SETUP to endpoint 0, resets both registers
  assign setup_rx = token_eop_in &&
                    setup_token_seen_in &&
                    address_match_in &&
                    endpoint_zero_hit_in &&
                    token_ok;  // [RL11] [RL17]

  // ---------------------------------------------------------------
  // Reply conditions
  // ---------------------------------------------------------------
  // Endpoint-0 NAK, endpoint-zero indicator clear
  assign ep0_nak_hit = token_eop_in &&
                       reserve[HS_EP0_NAK] &&
                       in_token_seen_in &&
                       token_pid_valid_in &&
                       address_match_in &&
                       !endpoint_zero_hit_in &&
                       token_ok;  // [RL1]
  // Data NAK also dropped on a clock watchdog fault
  assign data_nak_hit = data_rx_eop_in &&
                        reserve[HS_DATA_NAK] &&
                        out_token_seen_in &&
                        data_ok &&
                        !clock_watchdog_err_in;  // [RL2]
  // ACK on a clean data packet
  assign ack_hit = data_rx_eop_in &&
                   reserve[HS_ACK] &&
                   data_ok;  // [RL4]

  // ---------------------------------------------------------------
  // Timer start conditions, gated by arm flags
  // ---------------------------------------------------------------
  // Start after a clean data transmit
  assign tx_start_hit  = data_tx_eop_in &&
                         timer_arm[TMR_ARM_TX] &&
                         data_ok;  // [RL13] [RL15]
  // Start after a qualified SETUP or OUT token
  assign tok_start_hit = token_eop_in &&
                         timer_arm[TMR_ARM_TOKEN] &&
                         (out_token_seen_in || setup_token_seen_in) &&
                         address_match_in &&
                         endpoint_zero_hit_in &&
                         token_ok;  // [RL14] [RL15]

  // ---------------------------------------------------------------
  // Register file next state; SETUP reception beats a software write
  // ---------------------------------------------------------------
  always_comb begin
    next_timer_arm = timer_arm;
    next_reserve   = reserve;
    if (bus.wr_en) begin
      if (bus.wr_sel == SEL_TIMER) begin
        if (bus.wr_bit_mode) begin
          next_timer_arm[bus.wr_bit_idx] = bus.wr_data[0]; // [RL16]
        end else begin
          next_timer_arm = bus.wr_data; // [RL16]
        end
      end else begin
        if (bus.wr_bit_mode) begin
          next_reserve[bus.wr_bit_idx] = bus.wr_data[0]; // [RL18]
        end else begin
          next_reserve = bus.wr_data; // [RL18]
        end
      end
    end
    next_timer_arm = next_timer_arm & TIMER_MASK; // [RL12]
    if (setup_rx) begin
      next_timer_arm = TIMER_RST;     // [RL11]
      next_reserve   = HANDSHAKE_RST; // [RL17]
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_arm <= TIMER_RST;     // [RL10]
      reserve   <= HANDSHAKE_RST; // [RL17]
    end else begin
      timer_arm <= next_timer_arm;
      reserve   <= next_reserve;
    end
  end

  // ---------------------------------------------------------------
  // Reply pulses; data NAK outranks ACK when both qualify
  // ---------------------------------------------------------------
  always_comb begin
    next_nak   = ep0_nak_hit || data_nak_hit;
    next_ack   = ack_hit && !data_nak_hit;
    next_start = tx_start_hit || tok_start_hit;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nak_q   <= 1'b0;
      ack_q   <= 1'b0;
      start_q <= 1'b0;
    end else begin
      nak_q   <= next_nak;
      ack_q   <= next_ack;
      start_q <= next_start;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Reply pulses and register contents, all from flops
  assign nak_send_out     = nak_q;
  assign ack_send_out     = ack_q;
  assign timer_start_out  = start_q;
  assign bus.rd_timer     = timer_arm;
  assign bus.rd_handshake = reserve;
endmodule : ushr_dev
`default_nettype wire

// ===== ushr_ctl.sv
// APB controller that programs the reservation registers safely
`timescale 1ns/1ns
`default_nettype none
module ushr_ctl
  import ushr_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic [31:0]      prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Receive mode write mask
  output logic             rx_write_mask_out,
  // Device side
  ushr_if.ctl              bus
);
  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic       acc;
  logic       cmd_wr;
  logic       mask_wr;
  logic       mapped;
  logic [7:0] cur;
  logic [7:0] want;
  logic       bad;
  logic [2:0] idx;

  logic       wr_q;
  logic       sel_q;
  logic       bit_q;
  logic [2:0] idx_q;
  logic [7:0] data_q;
  logic       refused;
  logic       mask;
  logic       next_wr;
  logic       next_sel;
  logic       next_bit;
  logic [2:0] next_idx;
  logic [7:0] next_data;
  logic       next_refused;
  logic       next_mask;

  assign acc     = psel_in && penable_in;
  assign mapped  = (paddr_in == APB_CMD) || (paddr_in == APB_STATUS) ||
                   (paddr_in == APB_MASK);
  assign cmd_wr  = acc && pwrite_in && (paddr_in == APB_CMD);
  assign mask_wr = acc && pwrite_in && (paddr_in == APB_MASK);
  assign idx     = pwdata_in[CMD_IDX_HI:CMD_IDX_LO];
  assign cur     = bus.rd_handshake;

  // Value the handshake register would take
  always_comb begin
    want = cur;
    if (pwdata_in[CMD_BITMODE]) begin
      want[idx] = pwdata_in[0];
    end else begin
      want = pwdata_in[7:0];
    end
  end

  // Conflicting reservations are refused
  assign bad = (pwdata_in[CMD_SEL] == SEL_HANDSHAKE) &&
               ((want[HS_EP0_STALL] && want[HS_EP0_NAK]) ||  // [RL5]
                (want[HS_EP1_STALL] && want[HS_EP1_NAK]) ||  // [RL6]
                (want[HS_DATA_STALL] && want[HS_DATA_NAK]) ||
                (want[HS_ACK] && want[HS_DATA_NAK]));       // [RL7]

  // ---------------------------------------------------------------
  // Command launch, refusal flag and write mask
  // ---------------------------------------------------------------
  always_comb begin
    next_wr      = 1'b0;
    next_sel     = sel_q;
    next_bit     = bit_q;
    next_idx     = idx_q;
    next_data    = data_q;
    next_refused = refused;
    next_mask    = mask;
    if (mask_wr) begin
      next_mask = pwdata_in[0];
    end
    if (cmd_wr) begin
      next_refused = bad;
      if (!bad) begin
        next_wr   = 1'b1;
        next_sel  = pwdata_in[CMD_SEL];
        next_bit  = pwdata_in[CMD_BITMODE];
        next_idx  = idx;
        next_data = pwdata_in[7:0]; // [RL16]
        if ((pwdata_in[CMD_SEL] == SEL_HANDSHAKE) && want[HS_DATA_NAK] &&
            !cur[HS_DATA_NAK]) begin
          next_mask = 1'b1; // [RL8] [RL3]
        end
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_q    <= 1'b0;
      sel_q   <= SEL_TIMER;
      bit_q   <= 1'b0;
      idx_q   <= 3'h0;
      data_q  <= 8'h00;
      refused <= 1'b0;
      mask    <= 1'b0;
    end else begin
      wr_q    <= next_wr;
      sel_q   <= next_sel;
      bit_q   <= next_bit;
      idx_q   <= next_idx;
      data_q  <= next_data;
      refused <= next_refused;
      mask    <= next_mask;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    prdata_out = 32'h0000_0000;
    if (acc && !pwrite_in && (paddr_in == APB_STATUS)) begin
      prdata_out[7:0]                  = bus.rd_timer;
      prdata_out[STS_HS_LO +: 8]       = bus.rd_handshake;
      prdata_out[STS_REFUSED]          = refused;
      prdata_out[STS_MASK]             = mask;
    end else if (acc && !pwrite_in && (paddr_in == APB_MASK)) begin
      prdata_out[0] = mask;
    end
  end

  assign pready_out        = 1'b1;
  assign pslverr_out       = acc && !mapped;
  assign rx_write_mask_out = mask;
  assign bus.wr_en         = wr_q;
  assign bus.wr_sel        = sel_q;
  assign bus.wr_bit_mode   = bit_q;
  assign bus.wr_bit_idx    = idx_q;
  assign bus.wr_data       = data_q;
endmodule : ushr_ctl
`default_nettype wire

// ===== ushr_chk.sv
// Carrier checker for the reservation registers
`timescale 1ns/1ns
`default_nettype none
module ushr_chk (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Carrier signals
  input wire logic       wr_en,
  input wire logic       wr_sel,
  input wire logic       wr_bit_mode,
  input wire logic [2:0] wr_bit_idx,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_timer,
  input wire logic [7:0] rd_handshake
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Register contents against the writes that carry them
  chk_timer_fixed_zero: assert property (rd_timer[7:2] == 6'h00)
    else $error("timer arm upper bits set");
  chk_timer_byte_write: assert property (
    wr_en && !wr_sel && !wr_bit_mode |=> rd_timer == ($past(wr_data) & 8'h03))
    else $error("timer byte write lost");
  chk_hs_byte_write: assert property (
    wr_en && wr_sel && !wr_bit_mode |=> rd_handshake == $past(wr_data))
    else $error("handshake byte write lost");
  chk_timer_bit_write: assert property (
    wr_en && !wr_sel && wr_bit_mode && wr_bit_idx == 3'h0 |=>
    rd_timer[0] == $past(wr_data[0]) && $stable(rd_timer[1]))
    else $error("timer bit write wrong");
  chk_hs_bit_write: assert property (
    wr_en && wr_sel && wr_bit_mode |=>
    rd_handshake[$past(wr_bit_idx)] == $past(wr_data[0]))
    else $error("handshake bit write wrong");
  chk_timer_idle_hold: assert property (
    !wr_en && rd_timer == 8'h01 |=> rd_timer == 8'h01)
    else $error("timer arm changed without write");
  chk_hs_idle_hold: assert property (
    !wr_en && rd_handshake == 8'h00 |=> rd_handshake == 8'h00)
    else $error("handshake changed without write");
  chk_hs_no_conflict: assert property (
    !(rd_handshake[1] && (rd_handshake[0] || rd_handshake[4])) &&
    !(rd_handshake[2] && rd_handshake[6]) &&
    !(rd_handshake[3] && rd_handshake[7]))
    else $error("conflicting reservations held");
endmodule : ushr_chk
`default_nettype wire

// ===== usb_handshake_timer_reservation_tb.sv
// Bench for the reservation block and its controller
`timescale 1ns/1ns
`default_nettype none
module usb_handshake_timer_reservation_tb import ushr_pkg::*;;
  // Event vector bits
  localparam logic [16:0] TOK = 17'h00001, DRX = 17'h00002, DTX = 17'h00004;
  localparam logic [16:0] TIN = 17'h00008, TOUT = 17'h00010, TSET = 17'h00020;
  localparam logic [16:0] TPID = 17'h00040, ADR = 17'h00080, EP0 = 17'h00100;
  localparam logic [16:0] TCRC = 17'h00800, DPID = 17'h01000;
  localparam logic [16:0] DCRC = 17'h08000, WDOG = 17'h10000;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, mask, nak, ack, tmr, err;
  logic [16:0] ev = 17'h00000;
  logic [7:0]  v;
  int          bad_count = 0, tests_run = 0, cyc = 0;

  ushr_if bus_if ();
  ushr_dev ushr_dev_i (.clk_in(clk_in), .rst_in(rst_in), .bus(bus_if),
    .token_eop_in(ev[0]), .data_rx_eop_in(ev[1]), .data_tx_eop_in(ev[2]),
    .in_token_seen_in(ev[3]), .out_token_seen_in(ev[4]),
    .setup_token_seen_in(ev[5]), .token_pid_valid_in(ev[6]),
    .address_match_in(ev[7]), .endpoint_zero_hit_in(ev[8]),
    .token_length_err_in(ev[9]), .token_bit_err_in(ev[10]),
    .token_crc_err_in(ev[11]), .data_pid_valid_in(ev[12]),
    .data_length_err_in(ev[13]), .data_bit_err_in(ev[14]),
    .data_crc_err_in(ev[15]), .clock_watchdog_err_in(ev[16]),
    .nak_send_out(nak), .ack_send_out(ack), .timer_start_out(tmr));
  ushr_ctl ushr_ctl_i (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .rx_write_mask_out(mask), .bus(bus_if));
  ushr_chk ushr_chk_i (.clk_in(clk_in), .rst_in(rst_in),
    .wr_en(bus_if.wr_en), .wr_sel(bus_if.wr_sel),
    .wr_bit_mode(bus_if.wr_bit_mode), .wr_bit_idx(bus_if.wr_bit_idx),
    .wr_data(bus_if.wr_data), .rd_timer(bus_if.rd_timer),
    .rd_handshake(bus_if.rd_handshake));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic wr, input logic [31:0] a, d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do @(posedge clk_in); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [31:0] a, exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk

  // One EOP cycle, replies looked at one cycle later
  task automatic evt(input logic [16:0] e, input logic [2:0] exp, string nm);
    @(posedge clk_in);
    ev <= e;
    @(posedge clk_in);
    ev <= 17'h0;
    #1 chk(nm, {29'h0, exp}, {29'h0, nak, ack, tmr});
  endtask : evt

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done

  // Clock and hang guard
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rdchk(APB_STATUS, 32'h0000_0001, "reset status");
    apb(1'b1, APB_CMD, 32'h0000_00FF);
    rdchk(APB_STATUS, 32'h0000_0003, "timer byte");
    apb(1'b1, APB_CMD, 32'h0000_0200);
    rdchk(APB_STATUS, 32'h0000_0002, "timer bit");
    $display("test timer registers done");
    evt(DTX | DPID, 3'b001, "tx start");
    evt(TOK | TOUT | ADR | EP0, 3'b000, "token unarmed");
    apb(1'b1, APB_CMD, 32'h0000_0001);
    evt(TOK | TOUT | ADR | EP0, 3'b001, "token start");
    evt(TOK | TSET | ADR | EP0 | TCRC, 3'b000, "token crc");
    evt(DTX | DPID, 3'b000, "tx unarmed");
    $display("test timer start done");
    apb(1'b1, APB_CMD, 32'h0000_0101);
    apb(1'b1, APB_CMD, 32'h0000_0002);
    rdchk(APB_STATUS, 32'h0000_0102, "before setup");
    evt(TOK | TSET | ADR | EP0, 3'b000, "setup old arm");
    rdchk(APB_STATUS, 32'h0000_0001, "after setup");
    $display("test setup done");
    apb(1'b1, APB_CMD, 32'h0000_0101);
    evt(DRX | DPID, 3'b010, "ack");
    evt(DRX | DPID | DCRC, 3'b000, "ack crc");
    for (int i = 0; i < 4; i++) begin
      v = (i == 0) ? 8'h03 : (i == 1) ? 8'h12 : (i == 2) ? 8'h44 : 8'h88;
      apb(1'b1, APB_CMD, {24'h000001, v});
      rdchk(APB_STATUS, 32'h0001_0101, "conflict");
    end
    $display("test ack and conflicts done");
    apb(1'b1, APB_CMD, 32'h0000_0100);
    apb(1'b1, APB_CMD, 32'h0000_0701);
    rdchk(APB_STATUS, 32'h0002_0201, "nak mask");
    chk("mask pin", 32'h1, {31'h0, mask});
    evt(DRX | TOUT | DPID, 3'b100, "data nak");
    evt(DRX | TOUT | DPID | WDOG, 3'b000, "nak watchdog");
    apb(1'b1, APB_CMD, 32'h0000_0104);
    evt(TOK | TIN | TPID | ADR, 3'b100, "ep0 nak");
    evt(TOK | TIN | TPID | ADR | EP0, 3'b000, "ep0 nak hit");
    $display("test nak done");
    apb(1'b1, APB_MASK, 32'h0000_0000);
    rdchk(APB_STATUS, 32'h0000_0401, "mask cleared");
    rdchk(32'h0000_0010, 32'h0, "unmapped read");
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test mask and unmapped done");
    test_done();
  end
endmodule : usb_handshake_timer_reservation_tb
`default_nettype wire
